// ===== core/an_regs.svh
// Register map, fields and timing constants of the negotiation block
`ifndef AN_REGS_SVH
`define AN_REGS_SVH
// ==========================================================
// Management register addresses
`define REG_CONTROL 5'h00
`define REG_STATUS 5'h01
`define REG_ADVERT 5'h04
`define REG_PARTNER 5'h05
`define REG_IRQ 5'h10
// ==========================================================
// Register fields and reset values
`define CTRL_RESTART_BIT 9
`define CTRL_AN_EN_BIT 12
`define CTRL_AN_EN_RESET 1'h1
`define STAT_LINK_BIT 2
`define STAT_AN_ABLE_BIT 3
`define STAT_AN_DONE_BIT 5
`define IRQ_EN_BIT 0
`define IRQ_STATUS_BIT 1
`define ADVERT_RESET 16'h0020
// ==========================================================
// Ability word fields
`define CFG_SGMII_BIT 0
`define CFG_FD_BIT 5
`define CFG_PAUSE_LSB 7
`define CFG_PAUSE_MSB 8
`define CFG_SG_SPEED_LSB 10
`define CFG_SG_SPEED_MSB 11
`define CFG_SG_DUPLEX_BIT 12
`define CFG_RF_LSB 12
`define CFG_RF_MSB 13
`define CFG_ACK_BIT 14
`define SPEED_1000 2'h2
`define SGMII_MAC_WORD 16'h0001
`define CFG_ZERO 16'h0000
// ==========================================================
// Status vector fields
`define SV_LINK_BIT 0
`define SV_DONE_BIT 1
`define SV_SPEED_LSB 2
`define SV_SPEED_MSB 3
`define SV_DUPLEX_BIT 4
`define SV_RF_LSB 5
`define SV_RF_MSB 6
`define SV_PAUSE_LSB 7
`define SV_PAUSE_MSB 8
`define SV_BAD_SPEED_BIT 9
// ==========================================================
// Management frame opcodes and bit counts after the start pair
`define MDIO_OP_READ 2'h2
`define MDIO_OP_WRITE 2'h1
`define MDIO_IDX_HDR_END 5'h0B
`define MDIO_IDX_TA 5'h0C
`define MDIO_IDX_TA2 5'h0D
`define MDIO_IDX_LAST 5'h1D
// ==========================================================
// Timing
`define CLK_MHZ 10
`define LINK_TIMER_BASEX_US 10000
`define LINK_TIMER_SGMII_US 1600
`define TIMER_W 17
`endif

// ===== core/an_pkg.sv
// Types shared by the negotiation block
package an_pkg;
   typedef enum logic [2:0] {
      AN_DISABLED,
      AN_RESTART,
      AN_ABILITY,
      AN_ACK,
      AN_COMPLETE_ACK,
      AN_IDLE_DETECT,
      AN_LINK_OK
   } an_state_t;

   typedef enum logic [1:0] {
      MD_IDLE,
      MD_START,
      MD_FRAME
   } mdio_state_t;

   typedef enum logic [1:0] {
      OP_NONE,
      OP_READ,
      OP_WRITE
   } mdio_op_t;
endpackage

// ===== core/timer_if.sv
// Handshake between the negotiation state machine and its link timer
`timescale 1ns/1ps
interface timer_if;
   logic start;
   logic sgmii;
   logic expired;
   modport owner (output start, output sgmii, input expired);
   modport timer (input start, input sgmii, output expired);
endinterface

// ===== core/link_timer.sv
// Link timer with two durations, one per standard
`timescale 1ns/1ps
`include "an_regs.svh"
module link_timer #(
   parameter int unsigned BASEX_CYC = 100000,
   parameter int unsigned SGMII_CYC = 16000
) (
   input wire logic clk,
   input wire logic rst_n,
   timer_if.timer t
);
   logic [`TIMER_W-1:0] cnt_q, cnt_d;
   logic run_q, run_d;
   logic exp_q, exp_d;

   // A start reloads even while running, so a restart gets a full period
   always_comb begin
      cnt_d = cnt_q;
      run_d = run_q;
      exp_d = 1'b0;
      if (t.start) begin
         cnt_d = t.sgmii ? `TIMER_W'(SGMII_CYC - 1) : `TIMER_W'(BASEX_CYC - 1);
         run_d = 1'b1;
      end else if (run_q) begin
         if (cnt_q == '0) begin
            run_d = 1'b0;
            exp_d = 1'b1;
         end else begin
            cnt_d = cnt_q - `TIMER_W'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         run_q <= 1'b0;
         exp_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         run_q <= run_d;
         exp_q <= exp_d;
      end
   end

   assign t.expired = exp_q;
endmodule

// ===== core/pcs_auto_negotiation.sv
// Auto-negotiation with management registers, ability words and interrupt
// ==========================================================
// Overview of operation
// - Negotiate after reset, sync loss, partner start
// - Restart from control bit or restart pin
// - Send advertisement register while negotiating, fixed word in SGMII MAC mode
// - Advertisement carries fault, duplex and pause
// - Advertisement also loadable from tie vector
// - With management, load vector only on strobe
// - Capture partner abilities into partner register
// - Partner fault and pause on status vector outside SGMII mode
// - Set completion status bit when negotiation finishes
// - Link timer 10 ms, or 1.6 ms SGMII
// - SGMII word carries speed and duplex
// - SGMII speed and duplex on status vector
// - PHY mode advertises managed medium abilities
// - Interrupt controlled only through register 16
// - Interrupt held low while disabled
// - Interrupt rises on completion, stays until cleared
// - Writing zero to status bit clears interrupt
// - 2.5G behaves as 1G, no slow speeds
`timescale 1ns/1ps
`include "an_regs.svh"
module pcs_auto_negotiation #(
   parameter int unsigned LINK_TIMER_BASEX_CYC = `LINK_TIMER_BASEX_US * `CLK_MHZ,
   parameter int unsigned LINK_TIMER_SGMII_CYC = `LINK_TIMER_SGMII_US * `CLK_MHZ
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic mdc,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe,
   input wire logic [4:0] phy_addr,
   input wire logic mdio_present,
   input wire logic sgmii_mode,
   input wire logic phy_mode,
   input wire logic rate_2g5,
   input wire logic renegotiate_pin_request,
   input wire logic [15:0] advert_tie_bus,
   input wire logic advert_tie_strobe,
   input wire logic sync_ok,
   input wire logic rx_cfg_valid,
   input wire logic [15:0] rx_cfg_word,
   input wire logic rx_idle,
   output logic tx_cfg_en,
   output logic [15:0] tx_cfg_word,
   output logic [15:0] status_vector,
   output logic negotiation_done_irq
);
   // ==========================================================
   // Reset release
   logic [1:0] rst_sync_q;
   logic rst_n;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // ==========================================================
   // Declarations
   an_pkg::mdio_state_t md_state_q, md_state_d;
   an_pkg::mdio_op_t md_op_q, md_op_d;
   an_pkg::an_state_t st_q, st_d;
   logic mdc_q, mdc_rise;
   logic [4:0] md_cnt_q, md_cnt_d;
   logic [15:0] md_sh_q, md_sh_d;
   logic [4:0] md_reg_q, md_reg_d;
   logic md_out_q, md_out_d;
   logic md_oe_q, md_oe_d;
   logic [11:0] md_hdr;
   logic [4:0] rd_addr;
   logic [15:0] rd_data;
   logic wr_stb;
   logic [15:0] wr_data;
   logic an_en_q, an_en_d;
   logic [15:0] adv_q, adv_d;
   logic irq_en_q, irq_en_d;
   logic irq_stat_q, irq_stat_d;
   logic irq_q, irq_d;
   logic pin_q;
   logic restart_req;
   logic go_restart;
   logic complete_pulse;
   logic mode_q, mode_d;
   logic [15:0] partner_q, partner_d;
   logic done_q, done_d;
   logic tx_en_q, tx_en_d;
   logic [15:0] tx_word_q, tx_word_d;
   logic [15:0] adv_tx;
   logic [15:0] sv_q, sv_d;
   logic link_up;
   timer_if tmr ();

   link_timer #(
      .BASEX_CYC(LINK_TIMER_BASEX_CYC),
      .SGMII_CYC(LINK_TIMER_SGMII_CYC)
   ) u_link_timer (
      .clk(clk),
      .rst_n(rst_n),
      .t(tmr)
   );

   // ==========================================================
   // Management serial slave
   // Management clock is slow against clk, so its edges are found by sampling
   assign mdc_rise = mdc & ~mdc_q;
   assign md_hdr = {md_sh_q[10:0], mdio_in};
   assign rd_addr = md_hdr[4:0];
   assign wr_data = {md_sh_q[14:0], mdio_in};
   assign wr_stb = mdc_rise && (md_state_q == an_pkg::MD_FRAME) && (md_cnt_q == `MDIO_IDX_LAST)
                   && (md_op_q == an_pkg::OP_WRITE);

   always_comb begin
      md_state_d = md_state_q;
      md_op_d = md_op_q;
      md_cnt_d = md_cnt_q;
      md_sh_d = md_sh_q;
      md_reg_d = md_reg_q;
      md_out_d = md_out_q;
      md_oe_d = md_oe_q;
      if (mdc_rise) begin
         case (md_state_q)
            an_pkg::MD_IDLE: begin
               // A zero after preamble ones opens the start pair
               if (!mdio_in && md_sh_q[0]) begin
                  md_state_d = an_pkg::MD_START;
               end
               md_sh_d = {md_sh_q[14:0], mdio_in};
            end
            an_pkg::MD_START: begin
               md_state_d = mdio_in ? an_pkg::MD_FRAME : an_pkg::MD_IDLE;
               md_cnt_d = 5'h00;
               md_sh_d = {md_sh_q[14:0], mdio_in};
            end
            default: begin
               md_cnt_d = md_cnt_q + 5'h01;
               md_sh_d = {md_sh_q[14:0], mdio_in};
               if (md_cnt_q == `MDIO_IDX_HDR_END) begin
                  md_reg_d = md_hdr[4:0];
                  md_op_d = an_pkg::OP_NONE;
                  if (md_hdr[9:5] == phy_addr) begin
                     if (md_hdr[11:10] == `MDIO_OP_READ) begin
                        md_op_d = an_pkg::OP_READ;
                        md_sh_d = rd_data;
                     end else if (md_hdr[11:10] == `MDIO_OP_WRITE) begin
                        md_op_d = an_pkg::OP_WRITE;
                     end
                  end
               end else if (md_cnt_q == `MDIO_IDX_TA) begin
                  md_sh_d = md_sh_q;
                  if (md_op_q == an_pkg::OP_READ) begin
                     md_oe_d = 1'b1;
                     md_out_d = 1'b0;
                  end
               end else if (md_cnt_q == `MDIO_IDX_LAST) begin
                  md_oe_d = 1'b0;
                  md_out_d = 1'b0;
                  md_op_d = an_pkg::OP_NONE;
                  md_state_d = an_pkg::MD_IDLE;
                  md_sh_d = 16'h0000;
               end else if (md_op_q == an_pkg::OP_READ && md_cnt_q >= `MDIO_IDX_TA2) begin
                  md_out_d = md_sh_q[15];
                  md_sh_d = {md_sh_q[14:0], 1'b0};
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mdc_q <= 1'b0;
         md_state_q <= an_pkg::MD_IDLE;
         md_op_q <= an_pkg::OP_NONE;
         md_cnt_q <= 5'h00;
         md_sh_q <= 16'h0000;
         md_reg_q <= 5'h00;
         md_out_q <= 1'b0;
         md_oe_q <= 1'b0;
      end else begin
         mdc_q <= mdc;
         md_state_q <= md_state_d;
         md_op_q <= md_op_d;
         md_cnt_q <= md_cnt_d;
         md_sh_q <= md_sh_d;
         md_reg_q <= md_reg_d;
         md_out_q <= md_out_d;
         md_oe_q <= md_oe_d;
      end
   end

   assign mdio_out = md_out_q;
   assign mdio_oe = md_oe_q;

   // ==========================================================
   // Register read mux; unmapped addresses read zero
   always_comb begin
      rd_data = 16'h0000;
      if (rd_addr == `REG_CONTROL) begin
         rd_data[`CTRL_AN_EN_BIT] = an_en_q;
      end else if (rd_addr == `REG_STATUS) begin
         rd_data[`STAT_LINK_BIT] = link_up;
         rd_data[`STAT_AN_ABLE_BIT] = 1'b1;
         rd_data[`STAT_AN_DONE_BIT] = done_q;
      end else if (rd_addr == `REG_ADVERT) begin
         rd_data = adv_q;
      end else if (rd_addr == `REG_PARTNER) begin
         rd_data = partner_q;
      end else if (rd_addr == `REG_IRQ) begin
         rd_data[`IRQ_EN_BIT] = irq_en_q;
         rd_data[`IRQ_STATUS_BIT] = irq_stat_q;
      end
   end

   // ==========================================================
   // Writable registers and interrupt
   always_comb begin
      an_en_d = an_en_q;
      adv_d = adv_q;
      irq_en_d = irq_en_q;
      irq_stat_d = irq_stat_q;
      restart_req = renegotiate_pin_request & ~pin_q;
      if (!mdio_present) begin
         adv_d = advert_tie_bus;
      end else if (advert_tie_strobe) begin
         adv_d = advert_tie_bus;
      end
      if (wr_stb && md_reg_q == `REG_CONTROL) begin
         an_en_d = wr_data[`CTRL_AN_EN_BIT];
         restart_req = restart_req | wr_data[`CTRL_RESTART_BIT];
      end else if (wr_stb && md_reg_q == `REG_ADVERT) begin
         adv_d = wr_data;
      end else if (wr_stb && md_reg_q == `REG_IRQ) begin
         irq_en_d = wr_data[`IRQ_EN_BIT];
         if (!wr_data[`IRQ_STATUS_BIT]) begin
            irq_stat_d = 1'b0;
         end
      end
      // Completion in the clearing cycle is kept, so no event is lost
      if (complete_pulse && irq_en_d) begin
         irq_stat_d = 1'b1;
      end
      irq_d = irq_en_d & irq_stat_d;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         an_en_q <= `CTRL_AN_EN_RESET;
         adv_q <= `ADVERT_RESET;
         irq_en_q <= 1'b0;
         irq_stat_q <= 1'b0;
         irq_q <= 1'b0;
         pin_q <= 1'b0;
      end else begin
         an_en_q <= an_en_d;
         adv_q <= adv_d;
         irq_en_q <= irq_en_d;
         irq_stat_q <= irq_stat_d;
         irq_q <= irq_d;
         pin_q <= renegotiate_pin_request;
      end
   end

   assign negotiation_done_irq = irq_q;

   // ==========================================================
   // Ability word to send
   always_comb begin
      adv_tx = adv_q;
      if (mode_q && !phy_mode) begin
         adv_tx = `SGMII_MAC_WORD;
      end else if (mode_q) begin
         adv_tx[`CFG_SGMII_BIT] = 1'b1;
         if (rate_2g5) begin
            adv_tx[`CFG_SG_SPEED_MSB:`CFG_SG_SPEED_LSB] = `SPEED_1000;
         end
      end
   end

   // ==========================================================
   // Negotiation state machine
   // A disabled peer never completes; both ends must agree
   always_comb begin
      st_d = st_q;
      mode_d = mode_q;
      partner_d = partner_q;
      done_d = done_q;
      tx_en_d = tx_en_q;
      tx_word_d = tx_word_q;
      go_restart = 1'b0;
      complete_pulse = 1'b0;
      tmr.start = 1'b0;
      case (st_q)
         an_pkg::AN_RESTART: begin
            if (tmr.expired) begin
               st_d = an_pkg::AN_ABILITY;
               tx_word_d = adv_tx;
            end
         end
         an_pkg::AN_ABILITY: begin
            tx_word_d = adv_tx;
            if (rx_cfg_valid && (rx_cfg_word & ~(16'h0001 << `CFG_ACK_BIT)) != `CFG_ZERO) begin
               partner_d = rx_cfg_word;
               st_d = an_pkg::AN_ACK;
            end
         end
         an_pkg::AN_ACK: begin
            tx_word_d = adv_tx | (16'h0001 << `CFG_ACK_BIT);
            if (rx_cfg_valid && rx_cfg_word == `CFG_ZERO) begin
               go_restart = 1'b1;
            end else if (rx_cfg_valid && rx_cfg_word[`CFG_ACK_BIT]) begin
               partner_d = rx_cfg_word;
               st_d = an_pkg::AN_COMPLETE_ACK;
               tmr.start = 1'b1;
            end
         end
         an_pkg::AN_COMPLETE_ACK: begin
            if (rx_cfg_valid && rx_cfg_word == `CFG_ZERO) begin
               go_restart = 1'b1;
            end else if (tmr.expired) begin
               st_d = an_pkg::AN_IDLE_DETECT;
               tx_en_d = 1'b0;
               tmr.start = 1'b1;
            end
         end
         an_pkg::AN_IDLE_DETECT: begin
            if (rx_cfg_valid && rx_cfg_word == `CFG_ZERO) begin
               go_restart = 1'b1;
            end else if (tmr.expired && rx_idle) begin
               st_d = an_pkg::AN_LINK_OK;
               done_d = 1'b1;
               complete_pulse = 1'b1;
            end
         end
         an_pkg::AN_LINK_OK: begin
            if (rx_cfg_valid) begin
               go_restart = 1'b1;
            end
         end
         default: begin
            go_restart = 1'b1;
         end
      endcase
      // Mode latched at restart, so a mid-cycle change waits
      if (!an_en_q) begin
         st_d = an_pkg::AN_DISABLED;
         done_d = 1'b0;
         tx_en_d = 1'b0;
         tx_word_d = `CFG_ZERO;
         mode_d = sgmii_mode;
         tmr.start = 1'b0;
         complete_pulse = 1'b0;
      end else if (go_restart || restart_req || !sync_ok) begin
         st_d = an_pkg::AN_RESTART;
         mode_d = sgmii_mode;
         done_d = 1'b0;
         tx_en_d = 1'b1;
         tx_word_d = `CFG_ZERO;
         tmr.start = 1'b1;
         complete_pulse = 1'b0;
      end
   end

   assign tmr.sgmii = mode_d;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= an_pkg::AN_DISABLED;
         mode_q <= 1'b0;
         partner_q <= `CFG_ZERO;
         done_q <= 1'b0;
         tx_en_q <= 1'b0;
         tx_word_q <= `CFG_ZERO;
      end else begin
         st_q <= st_d;
         mode_q <= mode_d;
         partner_q <= partner_d;
         done_q <= done_d;
         tx_en_q <= tx_en_d;
         tx_word_q <= tx_word_d;
      end
   end

   assign tx_cfg_en = tx_en_q;
   assign tx_cfg_word = tx_word_q;

   // ==========================================================
   // Status vector
   assign link_up = an_en_q ? (st_q == an_pkg::AN_LINK_OK) : sync_ok;

   always_comb begin
      sv_d = 16'h0000;
      sv_d[`SV_LINK_BIT] = link_up;
      sv_d[`SV_DONE_BIT] = done_q;
      if (mode_q) begin
         sv_d[`SV_SPEED_MSB:`SV_SPEED_LSB] = partner_q[`CFG_SG_SPEED_MSB:`CFG_SG_SPEED_LSB];
         sv_d[`SV_DUPLEX_BIT] = partner_q[`CFG_SG_DUPLEX_BIT];
         // Slow speeds cannot be carried at 2.5G, so they are flagged instead
         sv_d[`SV_BAD_SPEED_BIT] = rate_2g5 && done_q
                                   && partner_q[`CFG_SG_SPEED_MSB:`CFG_SG_SPEED_LSB] != `SPEED_1000;
      end else begin
         sv_d[`SV_RF_MSB:`SV_RF_LSB] = partner_q[`CFG_RF_MSB:`CFG_RF_LSB];
         sv_d[`SV_PAUSE_MSB:`SV_PAUSE_LSB] = partner_q[`CFG_PAUSE_MSB:`CFG_PAUSE_LSB];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sv_q <= 16'h0000;
      end else begin
         sv_q <= sv_d;
      end
   end

   assign status_vector = sv_q;
endmodule

// ===== verification/pcs_auto_negotiation_asserts.sv
// Port-level checks of the negotiation block
`timescale 1ns/1ps
module pcs_auto_negotiation_asserts #(
   parameter int unsigned LINK_TIMER_BASEX_CYC = 20,
   parameter int unsigned LINK_TIMER_SGMII_CYC = 8
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic mdc,
   input wire logic mdio_out,
   input wire logic mdio_oe,
   input wire logic sgmii_mode,
   input wire logic renegotiate_pin_request,
   input wire logic sync_ok,
   input wire logic rx_cfg_valid,
   input wire logic [15:0] rx_cfg_word,
   input wire logic tx_cfg_en,
   input wire logic [15:0] tx_cfg_word,
   input wire logic [15:0] status_vector,
   input wire logic negotiation_done_irq
);
   // ==========================================================
   // Helper counters
   // Age skips the reset release chain
   logic [2:0] age_q, age_d;
   logic [31:0] zero_q, zero_d;
   always_comb begin
      age_d = (age_q == 3'h7) ? age_q : age_q + 3'h1;
      zero_d = (tx_cfg_en && tx_cfg_word == 16'h0000) ? zero_q + 32'h1 : 32'h0;
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         age_q <= 3'h0;
         zero_q <= 32'h0;
      end else begin
         age_q <= age_d;
         zero_q <= zero_d;
      end
   end
   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   AST_SYNC_RESTART: assert property (age_q == 3'h7 && !sync_ok |=> tx_cfg_en && tx_cfg_word == 16'h0000)
      else $error("no restart after sync loss");
   AST_PIN_RESTART: assert property (age_q == 3'h7 && $rose(renegotiate_pin_request) |=> tx_cfg_en && tx_cfg_word == 16'h0000)
      else $error("no restart after pin request");
   AST_ACK_REPLY: assert property (tx_cfg_en && tx_cfg_word != 16'h0000 && !tx_cfg_word[14] && rx_cfg_valid
      && rx_cfg_word != 16'h0000 |=> ##1 tx_cfg_word == ($past(tx_cfg_word, 2) | 16'h4000))
      else $error("ability not acknowledged");
   AST_LINK_TIMER: assert property (tx_cfg_en && tx_cfg_word != 16'h0000 && zero_q != 32'h0
      |-> zero_q == (sgmii_mode ? LINK_TIMER_SGMII_CYC : LINK_TIMER_BASEX_CYC) + 1)
      else $error("restart word length wrong");
   AST_DONE_AFTER_IDLE: assert property ($rose(status_vector[1]) |-> !tx_cfg_en && !$past(tx_cfg_en, 8))
      else $error("done without idle period");
   AST_IRQ_RISE: assert property ($rose(negotiation_done_irq) |-> ##[0:1] status_vector[1])
      else $error("interrupt without completion");
   AST_IRQ_FALL: assert property ($fell(negotiation_done_irq) |-> $past(mdc))
      else $error("interrupt fell without management write");
   AST_OE_RISE: assert property ($rose(mdio_oe) |-> $past(mdc) && !$past(mdc, 3))
      else $error("management drive not tied to clock rise");
endmodule

// ===== verification/link_partner_model.sv
// Remote partner that answers configuration words
`timescale 1ns/1ps
module link_partner_model (
   input wire logic clk,
   input wire logic tx_cfg_en,
   input wire logic [15:0] tx_cfg_word,
   input wire logic [15:0] ability,
   input wire logic slow,
   input wire logic kick,
   output logic rx_cfg_valid,
   output logic [15:0] rx_cfg_word,
   output logic rx_idle
);
   int gap;
   initial begin
      rx_cfg_valid = 1'b0;
      rx_cfg_word = 16'hFFFF;
      rx_idle = 1'b0;
      gap = 0;
   end
   always @(posedge clk) begin
      gap <= gap + 1;
      rx_idle <= !tx_cfg_en;
      if (kick) begin
         rx_cfg_valid <= 1'b1;
         rx_cfg_word <= 16'h0000;
      end else if (tx_cfg_en && gap >= (slow ? 11 : 2)) begin
         rx_cfg_valid <= 1'b1;
         rx_cfg_word <= (tx_cfg_word == 16'h0000) ? 16'h0000 : {ability[15], tx_cfg_word[14], ability[13:0]};
         gap <= 0;
      end else begin
         // Unqualified word toggles so nothing stale can pass for data
         rx_cfg_valid <= 1'b0;
         rx_cfg_word <= ~rx_cfg_word;
      end
   end
endmodule

// ===== verification/tb_pcs_auto_negotiation.sv
// Self-checking bench of the negotiation block
`timescale 1ns/1ps
module tb_pcs_auto_negotiation;
   localparam int unsigned BX = 20;
   localparam int unsigned SG = 8;
   logic clk, resetn, mdc, host_oe, host_bit, mdio_out, mdio_oe, sgmii_mode, phy_mode, rate_2g5, pin_req;
   logic strobe, sync_ok, slow, kick, rx_cfg_valid, rx_idle, tx_cfg_en, irq, seen, mdp;
   logic [15:0] tie_bus, pab, first_w, rd, adv_m, rx_cfg_word, tx_cfg_word, status_vector;
   logic [31:0] seed_q;
   wire mdio_in;
   int num_errors, checks_done, ien_m, irq_m;
   // Management line has a pull-up
   assign mdio_in = mdio_oe ? mdio_out : (host_oe ? host_bit : 1'b1);
   pcs_auto_negotiation #(.LINK_TIMER_BASEX_CYC(BX), .LINK_TIMER_SGMII_CYC(SG)) i_pcs_auto_negotiation (
      .clk, .resetn, .mdc, .mdio_in, .mdio_out, .mdio_oe, .phy_addr(5'h01), .mdio_present(mdp), .sgmii_mode,
      .phy_mode, .rate_2g5, .renegotiate_pin_request(pin_req), .advert_tie_bus(tie_bus), .advert_tie_strobe(strobe),
      .sync_ok, .rx_cfg_valid, .rx_cfg_word, .rx_idle, .tx_cfg_en, .tx_cfg_word, .status_vector,
      .negotiation_done_irq(irq));
   link_partner_model i_link_partner_model (.clk, .tx_cfg_en, .tx_cfg_word, .ability(pab), .slow, .kick,
      .rx_cfg_valid, .rx_cfg_word, .rx_idle);
   // ==========================================================
   // Helpers
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   function automatic logic [15:0] xs();
      seed_q ^= seed_q << 13;
      seed_q ^= seed_q >> 17;
      seed_q ^= seed_q << 5;
      return seed_q[15:0];
   endfunction
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk16({15'h0, got}, {15'h0, exp});
   endtask
   task automatic end_sim();
      if (num_errors == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // One management frame; read data lands in rd
   task automatic mdio(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd);
      logic [33:0] f;
      f = {4'hD, op, 5'h01, ra, 2'h2, wd};
      for (int i = 33; i >= 0; i--) begin
         mdc = 1'b0;
         host_oe = (op == 2'h1) || (i > 17);
         host_bit = f[i];
         tick(4);
         if (i < 16) rd = {rd[14:0], mdio_in};
         mdc = 1'b1;
         tick(4);
      end
      mdc = 1'b0;
      host_oe = 1'b0;
      tick(4);
   endtask
   task automatic wr(input logic [4:0] ra, input logic [15:0] d);
      mdio(2'h1, ra, d);
      if (ra == 5'h10) begin
         ien_m = d[0];
         if (!d[1]) irq_m = 0;
      end
   endtask
   task automatic rdchk(input logic [4:0] ra, input logic [15:0] mask, input logic [15:0] exp);
      mdio(2'h2, ra, 16'h0000);
      chk16(rd & mask, exp & mask);
   endtask
   always @(posedge clk) begin
      if (!seen && tx_cfg_en === 1'b1 && tx_cfg_word !== 16'h0000) begin
         first_w <= tx_cfg_word;
         seen <= 1'b1;
      end
   end
   // Start a negotiation, wait for it, compare results
   task automatic run(input int how, input logic [15:0] exp_w);
      int n;
      if (how != 4) pab = (xs() & 16'h3F9E) | 16'h0020;
      seen = 1'b0;
      case (how)
         0: wr(5'h00, 16'h1200);
         1: begin pin_req = 1'b1; tick(2); pin_req = 1'b0; end
         2: begin sync_ok = 1'b0; tick(1); sync_ok = 1'b1; end
         3: begin kick = 1'b1; tick(1); kick = 1'b0; end
         default: ;
      endcase
      tick(3);
      n = 0;
      while (status_vector[1] !== 1'b1 && n < 3000) begin
         tick(1);
         n++;
      end
      if (ien_m != 0) irq_m = 1;
      tick(2);
      chk1(&status_vector[1:0], 1'b1);
      chk16(first_w, exp_w);
      chk1(irq, (irq_m & ien_m) != 0);
      if (sgmii_mode) begin
         chk16({12'h0, status_vector[9], status_vector[4:2]}, {12'h0, rate_2g5 && pab[11:10] != 2'h2, pab[12:10]});
      end else begin
         chk16({12'h0, status_vector[8:5]}, {12'h0, pab[8:7], pab[13:12]});
      end
      rdchk(5'h05, 16'hFFFF, pab | 16'h4000);
      rdchk(5'h01, 16'h0024, 16'h0024);
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      {resetn, mdc, host_oe, host_bit, sgmii_mode, phy_mode, rate_2g5, pin_req, strobe, slow, kick, seen} = '0;
      {tie_bus, first_w, rd} = '0;
      {sync_ok, mdp} = 2'h3;
      num_errors = 0;
      checks_done = 0;
      ien_m = 0;
      irq_m = 0;
      seed_q = 32'h0915;
      pab = (xs() & 16'h3F9E) | 16'h0020;
      tick(4);
      resetn = 1'b1;
      tick(3);
      run(4, 16'h0020);
      rdchk(5'h00, 16'h1200, 16'h1000);
      rdchk(5'h01, 16'h0008, 16'h0008);
      rdchk(5'h02, 16'hFFFF, 16'h0000);
      rdchk(5'h10, 16'hFFFF, 16'h0000);
      wr(5'h10, 16'h0001);
      adv_m = (xs() & 16'hBFFF) | 16'h0020;
      wr(5'h04, adv_m);
      wr(5'h01, 16'hFFFF);
      wr(5'h05, 16'h0000);
      rdchk(5'h04, 16'hFFFF, adv_m);
      slow = 1'b1;
      run(0, adv_m);
      wr(5'h10, 16'h0003);
      chk1(irq, 1'b1);
      wr(5'h10, 16'h0001);
      chk1(irq, 1'b0);
      rdchk(5'h10, 16'hFFFF, 16'h0001);
      tie_bus = (xs() & 16'hBFFF) | 16'h0020;
      strobe = 1'b1;
      tick(1);
      {strobe, adv_m, tie_bus} = {1'b0, tie_bus, ~tie_bus};
      tick(2);
      rdchk(5'h04, 16'hFFFF, adv_m);
      mdp = 1'b0;
      rdchk(5'h04, 16'hFFFF, tie_bus);
      tie_bus = adv_m;
      tick(1);
      mdp = 1'b1;
      slow = 1'b0;
      run(2, adv_m);
      wr(5'h10, 16'h0000);
      chk1(irq, 1'b0);
      run(3, adv_m);
      sgmii_mode = 1'b1;
      for (int k = 0; k < 3; k++) begin
         phy_mode = (k > 0);
         rate_2g5 = (k == 2);
         run(1, k == 0 ? 16'h0001 : (k == 1 ? adv_m | 16'h0001 : (adv_m & 16'hF3FF) | 16'h0801));
      end
      end_sim();
   end
   initial begin
      repeat (40000) @(posedge clk);
      num_errors++;
      end_sim();
   end
endmodule
bind pcs_auto_negotiation pcs_auto_negotiation_asserts #(.LINK_TIMER_BASEX_CYC(LINK_TIMER_BASEX_CYC),
   .LINK_TIMER_SGMII_CYC(LINK_TIMER_SGMII_CYC)) i_pcs_auto_negotiation_asserts (.clk, .resetn, .mdc, .mdio_out,
   .mdio_oe, .sgmii_mode, .renegotiate_pin_request, .sync_ok, .rx_cfg_valid, .rx_cfg_word, .tx_cfg_en, .tx_cfg_word,
   .status_vector, .negotiation_done_irq);
